// ---- logic/scr_mtp_seq.sv ----
// Purpose: Runs one MTP page program or chip erase and reports busy.
// Assumes: Page-buffer RAM read data valid in the same cycle as its address.
// Notes:   Low nibble of each byte sits at the even buffer address.
`timescale 1ns/100ps
module scr_mtp_seq
   import scr_pkg::*;
#(
   parameter int BYTES = BYTES_PER_PG
) (
   input  wire logic                  clock_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  ce_i,
   input  wire logic                  start_prog_i,
   input  wire logic                  start_erase_i,
   input  wire logic [PAGE_W-1:0]     page_i,
   output logic      [ADDR_W-1:0]     ram_addr_o,
   input  wire logic [DATA_W-1:0]     ram_rdata_i,
   output logic      [MTP_ADDR_W-1:0] mtp_addr_o,
   output logic      [7:0]            mtp_wdata_o,
   output logic                       mtp_write_o,
   output logic                       mtp_erase_o,
   input  wire logic                  mtp_done_i,
   output logic                       busy_o,
   output logic                       finish_o
);
   localparam int IDX_W = $clog2(BYTES);

   scr_seq_state_t    state;
   scr_seq_state_t    next_state;
   logic [IDX_W-1:0]  idx;
   logic [PAGE_W-1:0] page;
   logic [3:0]        lo_nib;
   logic [3:0]        hi_nib;
   wire               last_byte = (idx == IDX_W'(BYTES - 1));

   always_comb begin
      next_state = state;
      case (state)
         SEQ_IDLE: begin
            if (start_erase_i) begin
               next_state = SEQ_ERASE;
            end else if (start_prog_i) begin
               next_state = SEQ_LO;
            end
         end
         SEQ_ERASE: begin
            if (mtp_done_i) begin
               next_state = SEQ_IDLE;
            end
         end
         SEQ_LO:  next_state = SEQ_HI;
         SEQ_HI:  next_state = SEQ_WR;
         SEQ_WR: begin
            if (mtp_done_i) begin
               next_state = last_byte ? SEQ_IDLE : SEQ_LO;
            end
         end
         default: next_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state  <= SEQ_IDLE;
         idx    <= '0;
         page   <= '0;
         lo_nib <= ZERO_NIB;
         hi_nib <= ZERO_NIB;
      end else if (ce_i) begin
         state <= next_state;
         if (state == SEQ_IDLE) begin
            idx  <= '0;
            page <= page_i;
         end
         if (state == SEQ_LO) begin
            lo_nib <= ram_rdata_i;                             // [R15]
         end
         if (state == SEQ_HI) begin
            hi_nib <= ram_rdata_i;                             // [R15]
         end
         if (state == SEQ_WR && mtp_done_i) begin
            idx <= idx + 1'b1;
         end
      end
   end

   // Page buffer walk: two nibbles per MTP byte
   assign ram_addr_o  = ADDR_PG_BUF + ADDR_W'({idx, (state == SEQ_HI)});
   assign mtp_addr_o  = {page, idx};                           // [R15]
   assign mtp_wdata_o = {hi_nib, lo_nib};
   assign mtp_write_o = (state == SEQ_WR);
   assign mtp_erase_o = (state == SEQ_ERASE);                  // [R3]
   assign busy_o      = (state != SEQ_IDLE);                   // [R4] [R5]
   assign finish_o    = ce_i && mtp_done_i && ((state == SEQ_ERASE) || (state == SEQ_WR && last_byte));
endmodule : scr_mtp_seq

// ---- logic/scr_pkg.sv ----
// Purpose: Shared constants for the nibble-wide system control register bank.
// Assumes: Nibble data, 9-bit data memory address from the core.
// Notes:   Offsets are byte-free word addresses in the core's data space.
package scr_pkg;
   localparam int           DATA_W        = 4;
   localparam int           ADDR_W        = 9;
   localparam int           PAGE_W        = 6;
   localparam int           MTP_ADDR_W    = 10;
   localparam int           BYTES_PER_PG  = 16;

   localparam logic [8:0]   ADDR_PAGE_LOW = 9'h1e0;
   localparam logic [8:0]   ADDR_PAGE_HI  = 9'h1e1;
   localparam logic [8:0]   ADDR_MTP_CTL  = 9'h1e2;
   localparam logic [8:0]   ADDR_KEY      = 9'h1e3;
   localparam logic [8:0]   ADDR_PORT_A   = 9'h1e4;
   localparam logic [8:0]   ADDR_PORT_B   = 9'h1e5;
   localparam logic [8:0]   ADDR_PORT_C   = 9'h1e6;
   localparam logic [8:0]   ADDR_PORT_D   = 9'h1e7;
   localparam logic [8:0]   ADDR_TMR_CS   = 9'h1e8;
   localparam logic [8:0]   ADDR_SUPPLY   = 9'h1e9;
   localparam logic [8:0]   ADDR_PG_BUF   = 9'h1a0;

   localparam int           CTL_DONE_BIT  = 0;
   localparam int           CTL_RDEN_BIT  = 1;
   localparam int           CTL_PROG_BIT  = 2;
   localparam int           CTL_ERASE_BIT = 3;
   localparam int           SUP_LVD_BIT   = 0;
   localparam int           SUP_POR_BIT   = 1;

   localparam logic [3:0]   KEY_VALUE     = 4'h000a;
   localparam logic [3:0]   RST_PAGE      = 4'h0000;
   localparam logic [3:0]   RST_PORT      = 4'h000f;
   localparam logic [0:0]   RST_PORT_D    = 1'b1;
   localparam logic [1:0]   RST_TMR_CS    = 2'h3;
   localparam logic         RST_RDEN      = 1'b1;
   localparam logic         RST_POR       = 1'b1;
   localparam logic [3:0]   ZERO_NIB      = 4'h0000;

   // Timer0 source codes
   localparam logic [1:0]   TCS_1MHZ      = 2'h0;
   localparam logic [1:0]   TCS_2MHZ      = 2'h1;
   localparam logic [1:0]   TCS_4MHZ      = 2'h2;
   localparam logic [1:0]   TCS_8MHZ      = 2'h3;

   typedef enum logic [4:0] {
      SEQ_IDLE  = 5'b00001,
      SEQ_ERASE = 5'b00010,
      SEQ_LO    = 5'b00100,
      SEQ_HI    = 5'b01000,
      SEQ_WR    = 5'b10000
   } scr_seq_state_t;
endpackage : scr_pkg

// ---- logic/scr_reg_bank.sv ----
// Purpose: Nibble-wide system control registers: MTP control, ports, Timer0 source, supply flags.
// Assumes: Core data-memory access, pads open-drain low with pull-up.
// Notes:   Read data is registered one cycle after the read strobe.
// Behaviour
// [R1] Key 0xA arms exactly one MTP operation
// [R2] Control bit 2 starts armed page program
// [R3] Control bit 3 starts armed chip erase
// [R4] Bit 0 reads busy during page program
// [R5] Bit 0 reads busy during chip erase
// [R6] Bit 0 is read/write finish flag, reset zero
// [R7] Bit 1 enables MTP reads, resets one
// [R8] Port reads return pads; writes set latches
// [R9] Port latches reset ones; port D upper zero
// [R10] Single-bit port reads pad, writes latch
// [R11] Timer0 source codes 1/2/4/8 MHz, reset 11
// [R12] Supply bit 0 read-only threshold status
// [R13] Power-on flag cleared only by writing zero
// [R14] Latch one: pulled-up input; zero: drive low
// [R15] Program copies RAM page buffer into page
// [R16] Non-low-voltage resets set power-on flag
// [R17] Page number is high field over low
// [R18] Each started operation drops the key arming
`timescale 1ns/100ps
module scr_reg_bank
   import scr_pkg::*;
#(
   parameter int PORT_W = 4
) (
   input  wire logic                  clock_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  pwr_rst_n_i,
   input  wire logic                  ce_i,
   input  wire logic                  lvr_cause_i,
   input  wire logic [ADDR_W-1:0]     addr_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   input  wire logic [DATA_W-1:0]     wdata_i,
   output logic      [DATA_W-1:0]     rdata_o,
   input  wire logic [PORT_W-1:0]     pa_pad_i,
   input  wire logic [PORT_W-1:0]     pb_pad_i,
   input  wire logic [PORT_W-1:0]     pc_pad_i,
   input  wire logic                  pd_pad_i,
   output logic      [PORT_W-1:0]     pa_out_o,
   output logic      [PORT_W-1:0]     pa_oe_o,
   output logic      [PORT_W-1:0]     pa_pullup_o,
   output logic      [PORT_W-1:0]     pb_out_o,
   output logic      [PORT_W-1:0]     pb_oe_o,
   output logic      [PORT_W-1:0]     pb_pullup_o,
   output logic      [PORT_W-1:0]     pc_out_o,
   output logic      [PORT_W-1:0]     pc_oe_o,
   output logic      [PORT_W-1:0]     pc_pullup_o,
   output logic                       pd_out_o,
   output logic                       pd_oe_o,
   output logic                       pd_pullup_o,
   output logic      [1:0]            timer_clock_select_o,
   input  wire logic                  lvd_above_i,
   output logic                       mtp_read_en_o,
   output logic      [ADDR_W-1:0]     ram_addr_o,
   input  wire logic [DATA_W-1:0]     ram_rdata_i,
   output logic      [MTP_ADDR_W-1:0] mtp_addr_o,
   output logic      [7:0]            mtp_wdata_o,
   output logic                       mtp_write_o,
   output logic                       mtp_erase_o,
   input  wire logic                  mtp_done_i
);
   logic [3:0]        mtp_page_low;
   logic [1:0]        mtp_page_high;
   logic              finish_flag;
   logic              read_enable;
   logic              armed;
   logic [PORT_W-1:0] port_a_data;
   logic [PORT_W-1:0] port_b_data;
   logic [PORT_W-1:0] port_c_data;
   logic              port_d_data;
   logic [1:0]        timer_clock_select;
   logic              por_flag;
   logic              first_cycle;
   logic              busy;
   logic              finish;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   function automatic logic [DATA_W-1:0] pad_nib(input logic [PORT_W-1:0] pads);
      pad_nib = DATA_W'(pads);
   endfunction : pad_nib

   wire wr_page_lo = wr_i && hit(addr_i, ADDR_PAGE_LOW);
   wire wr_page_hi = wr_i && hit(addr_i, ADDR_PAGE_HI);
   wire wr_ctl     = wr_i && hit(addr_i, ADDR_MTP_CTL);
   wire wr_key     = wr_i && hit(addr_i, ADDR_KEY);
   wire wr_pa      = wr_i && hit(addr_i, ADDR_PORT_A);
   wire wr_pb      = wr_i && hit(addr_i, ADDR_PORT_B);
   wire wr_pc      = wr_i && hit(addr_i, ADDR_PORT_C);
   wire wr_pd      = wr_i && hit(addr_i, ADDR_PORT_D);
   wire wr_tcs     = wr_i && hit(addr_i, ADDR_TMR_CS);
   wire wr_sup     = wr_i && hit(addr_i, ADDR_SUPPLY);

   // Starts are ignored while an operation runs; erase wins if both bits are set
   wire go_erase   = wr_ctl && wdata_i[CTL_ERASE_BIT] && armed && !busy;   // [R3]
   wire go_prog    = wr_ctl && wdata_i[CTL_PROG_BIT] && armed && !busy
                     && !wdata_i[CTL_ERASE_BIT];                           // [R2]
   wire [PAGE_W-1:0] page_num = {mtp_page_high, mtp_page_low};            // [R17]

   scr_mtp_seq #(
      .BYTES         (BYTES_PER_PG)
   ) u_seq (
      .clock_i       (clock_i),
      .rst_n_i       (rst_n_i),
      .ce_i          (ce_i),
      .start_prog_i  (go_prog),
      .start_erase_i (go_erase),
      .page_i        (page_num),
      .ram_addr_o    (ram_addr_o),
      .ram_rdata_i   (ram_rdata_i),
      .mtp_addr_o    (mtp_addr_o),
      .mtp_wdata_o   (mtp_wdata_o),
      .mtp_write_o   (mtp_write_o),
      .mtp_erase_o   (mtp_erase_o),
      .mtp_done_i    (mtp_done_i),
      .busy_o        (busy),
      .finish_o      (finish)
   );

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mtp_page_low  <= RST_PAGE;
         mtp_page_high <= RST_PAGE[1:0];
      end else if (ce_i) begin
         if (wr_page_lo) begin
            mtp_page_low <= wdata_i;
         end
         if (wr_page_hi) begin
            mtp_page_high <= wdata_i[1:0];                     // [R17]
         end
      end
   end

   // Any key write re-decides arming; a start consumes it
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed <= 1'b0;
      end else if (ce_i) begin
         if (go_prog || go_erase) begin
            armed <= 1'b0;                                     // [R18]
         end else if (wr_key) begin
            armed <= (wdata_i == KEY_VALUE);                   // [R1]
         end
      end
   end

   // Completion sets the flag; it wins over a software write in the same cycle
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         finish_flag <= 1'b0;                                  // [R6]
         read_enable <= RST_RDEN;                              // [R7]
      end else if (ce_i) begin
         if (finish) begin
            finish_flag <= 1'b1;                               // [R6]
         end else if (go_prog || go_erase) begin
            finish_flag <= 1'b0;
         end else if (wr_ctl) begin
            finish_flag <= wdata_i[CTL_DONE_BIT];              // [R6]
         end
         if (wr_ctl) begin
            read_enable <= wdata_i[CTL_RDEN_BIT];              // [R7]
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port_a_data        <= PORT_W'(RST_PORT);              // [R9]
         port_b_data        <= PORT_W'(RST_PORT);              // [R9]
         port_c_data        <= PORT_W'(RST_PORT);              // [R9]
         port_d_data        <= RST_PORT_D[0];                  // [R9]
         timer_clock_select <= RST_TMR_CS;                     // [R11]
      end else if (ce_i) begin
         if (wr_pa) begin
            port_a_data <= PORT_W'(wdata_i);                   // [R8]
         end
         if (wr_pb) begin
            port_b_data <= PORT_W'(wdata_i);                   // [R8]
         end
         if (wr_pc) begin
            port_c_data <= PORT_W'(wdata_i);                   // [R8]
         end
         if (wr_pd) begin
            port_d_data <= wdata_i[0];                         // [R10]
         end
         if (wr_tcs) begin
            timer_clock_select <= wdata_i[1:0];                // [R11]
         end
      end
   end

   // Power-on flag survives system resets; only power-up reset loads its start value of one.
   // A system reset release re-sets it unless the low-voltage detector caused it.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first_cycle <= 1'b1;
      end else if (ce_i) begin
         first_cycle <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge pwr_rst_n_i) begin
      if (!pwr_rst_n_i) begin
         por_flag <= RST_POR;
      end else if (ce_i) begin
         if (first_cycle && !lvr_cause_i) begin
            por_flag <= 1'b1;                                  // [R16]
         end else if (wr_sup && !wdata_i[SUP_POR_BIT]) begin
            por_flag <= 1'b0;                                  // [R13]
         end
      end
   end

   // Read mux: unmapped addresses and reserved bits read zero
   wire [DATA_W-1:0] ctl_rd = {2'b00, read_enable, finish_flag | busy};       // [R4] [R5]
   wire [DATA_W-1:0] sup_rd = {2'b00, por_flag, lvd_above_i};                 // [R12]
   wire [DATA_W-1:0] rd_mux =
      hit(addr_i, ADDR_PAGE_LOW) ? mtp_page_low :
      hit(addr_i, ADDR_PAGE_HI)  ? {2'b00, mtp_page_high} :                   // [R17]
      hit(addr_i, ADDR_MTP_CTL)  ? ctl_rd :
      hit(addr_i, ADDR_PORT_A)   ? pad_nib(pa_pad_i) :                        // [R8]
      hit(addr_i, ADDR_PORT_B)   ? pad_nib(pb_pad_i) :                        // [R8]
      hit(addr_i, ADDR_PORT_C)   ? pad_nib(pc_pad_i) :                        // [R8]
      hit(addr_i, ADDR_PORT_D)   ? {3'b000, pd_pad_i} :                       // [R9] [R10]
      hit(addr_i, ADDR_TMR_CS)   ? {2'b00, timer_clock_select} :
      hit(addr_i, ADDR_SUPPLY)   ? sup_rd : ZERO_NIB;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= ZERO_NIB;
      end else if (ce_i && rd_i) begin
         rdata_o <= rd_mux;
      end
   end

   // Open-drain pads: a zero latch drives low, a one releases with pull-up
   assign pa_out_o    = '0;
   assign pa_oe_o     = ~port_a_data;                          // [R14]
   assign pa_pullup_o = port_a_data;                           // [R14]
   assign pb_out_o    = '0;
   assign pb_oe_o     = ~port_b_data;                          // [R14]
   assign pb_pullup_o = port_b_data;                           // [R14]
   assign pc_out_o    = '0;
   assign pc_oe_o     = ~port_c_data;                          // [R14]
   assign pc_pullup_o = port_c_data;                           // [R14]
   assign pd_out_o    = 1'b0;
   assign pd_oe_o     = ~port_d_data;                          // [R14]
   assign pd_pullup_o = port_d_data;                           // [R14]

   assign timer_clock_select_o = timer_clock_select;           // [R11]
   assign mtp_read_en_o        = read_enable;                  // [R7]
endmodule : scr_reg_bank

// ---- testbench/scr_far_model.sv ----
// Purpose: Far side: page-buffer RAM, MTP array timing and pads.
// Assumes: Pads pulled up; an outside load may pull some low.
// Notes:   slow_i stretches MTP ops.
`timescale 1ns/100ps
module scr_far_model (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        slow_i,
   input  wire logic [8:0]  ram_addr_i,
   output logic      [3:0]  ram_rdata_o,
   input  wire logic        mtp_write_i,
   input  wire logic        mtp_erase_i,
   output logic             mtp_done_o,
   input  wire logic [12:0] oe_i,
   input  wire logic [12:0] pullup_i,
   input  wire logic [12:0] ext_i,
   output logic      [12:0] pad_o
);
   logic [3:0] wait_cnt;
   wire  [3:0] wait_lim = slow_i ? 4'h9 : 4'h1;
   // Swapped nibbles show up
   assign ram_rdata_o = ram_addr_i[3:0] ^ {3'b000, ram_addr_i[4]} ^ 4'h6;
   // A driven pin wins
   assign pad_o = ~oe_i & pullup_i & ext_i;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_cnt   <= 4'h0;
         mtp_done_o <= 1'b0;
      end else begin
         mtp_done_o <= 1'b0;
         if ((mtp_write_i || mtp_erase_i) && !mtp_done_o) begin
            if (wait_cnt == wait_lim) begin
               mtp_done_o <= 1'b1;
               wait_cnt   <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule : scr_far_model

// ---- testbench/scr_reg_bank_asserts.sv ----
// Purpose: Concurrent checks on the ports of scr_reg_bank.
// Assumes: One clock domain; ce_i qualifies every bus access.
// Notes:   Bound below.
`timescale 1ns/100ps
module scr_reg_bank_chk
   import scr_pkg::*;
#(
   parameter int PORT_W = 4
) (
   input  wire logic                  clock_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  ce_i,
   input  wire logic [ADDR_W-1:0]     addr_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   input  wire logic [DATA_W-1:0]     wdata_i,
   input  wire logic [DATA_W-1:0]     rdata_o,
   input  wire logic [PORT_W-1:0]     pa_out_o,
   input  wire logic [PORT_W-1:0]     pa_oe_o,
   input  wire logic [PORT_W-1:0]     pa_pullup_o,
   input  wire logic                  pd_pad_i,
   input  wire logic [1:0]            timer_clock_select_o,
   input  wire logic                  lvd_above_i,
   input  wire logic                  mtp_read_en_o,
   input  wire logic [MTP_ADDR_W-1:0] mtp_addr_o,
   input  wire logic [7:0]            mtp_wdata_o,
   input  wire logic                  mtp_write_o,
   input  wire logic                  mtp_erase_o,
   input  wire logic                  mtp_done_i
);
   wire wr_en = wr_i & ce_i;
   wire rd_en = rd_i & ce_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Arming only counts when neither mtp_write_o nor mtp_erase_o is high
   sequence s_arm;
      wr_en && addr_i == ADDR_KEY && wdata_i == 4'ha && !mtp_write_o && !mtp_erase_o;
   endsequence
   sequence s_erase_cmd;
      wr_en && addr_i == ADDR_MTP_CTL && wdata_i[3];
   endsequence
   a_armed_erase_starts: assert property (s_arm ##2 s_erase_cmd |=> mtp_erase_o)
      else $error("erase not started");
   a_port_latch: assert property (wr_en && addr_i == ADDR_PORT_A |=> pa_pullup_o == $past(wdata_i))
      else $error("port latch wrong");
   a_port_drive_low: assert property (pa_out_o == 4'h0 && pa_oe_o == ~pa_pullup_o)
      else $error("port pin mode wrong");
   a_tcs_write: assert property (wr_en && addr_i == ADDR_TMR_CS |=> timer_clock_select_o == $past(wdata_i[1:0]))
      else $error("timer source wrong");
   a_rden_write: assert property (wr_en && addr_i == ADDR_MTP_CTL |=> mtp_read_en_o == $past(wdata_i[1]))
      else $error("read enable wrong");
   a_pd_read: assert property (rd_en && addr_i == ADDR_PORT_D |=> rdata_o == {3'b000, $past(pd_pad_i)})
      else $error("port d read wrong");
   a_lvd_read: assert property (rd_en && addr_i == ADDR_SUPPLY |=> rdata_o[0] == $past(lvd_above_i))
      else $error("lvd read wrong");
   a_write_hold: assert property (mtp_write_o && !mtp_done_i |=> mtp_write_o && $stable(mtp_addr_o)
      && $stable(mtp_wdata_o))
      else $error("write dropped");
   a_write_release: assert property (mtp_write_o && mtp_done_i && ce_i |=> !mtp_write_o)
      else $error("write held");
   a_erase_hold: assert property (mtp_erase_o && !mtp_done_i |=> mtp_erase_o)
      else $error("erase dropped");
endmodule : scr_reg_bank_chk
bind scr_reg_bank scr_reg_bank_chk #(.PORT_W(PORT_W)) u_chk (.*);

// ---- testbench/scr_reg_bank_tb_top.sv ----
// Purpose: Self-checking bench for scr_reg_bank.
// Assumes: Far model gives RAM, MTP timing and pads.
// Notes:   Scenario tasks judge their own results; a monitor judges each MTP byte write.
`timescale 1ns/100ps
module scr_reg_bank_tb_top
   import scr_pkg::*;
;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, pwr_rst_n_i = 1'b0, ce_i = 1'b1, lvr_cause_i = 1'b0;
   logic        wr_i = 1'b0, rd_i = 1'b0, lvd_above_i = 1'b1, slow = 1'b0;
   logic [8:0]  addr_i = 9'h000;
   logic [3:0]  wdata_i = 4'h0, ext = 4'hf;
   logic [3:0]  rdata, pa_out, pa_oe, pa_pu, pb_out, pb_oe, pb_pu, pc_out, pc_oe, pc_pu, ram_rdata;
   logic        pd_out, pd_oe, pd_pu, rden, mtp_wr, mtp_er, mtp_done;
   logic [1:0]  tcs;
   logic [8:0]  ram_addr;
   logic [9:0]  mtp_addr;
   logic [7:0]  mtp_wdata;
   logic [12:0] pad;
   logic [5:0]  exp_page = 6'h00;
   int          fail_count = 0, samples_checked = 0, nbytes = 0;

   scr_reg_bank #(.PORT_W(4)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pwr_rst_n_i(pwr_rst_n_i), .ce_i(ce_i), .lvr_cause_i(lvr_cause_i),
      .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata), .pa_pad_i(pad[12:9]),
      .pb_pad_i(pad[8:5]), .pc_pad_i(pad[4:1]), .pd_pad_i(pad[0]), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
      .pa_pullup_o(pa_pu), .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pullup_o(pb_pu), .pc_out_o(pc_out),
      .pc_oe_o(pc_oe), .pc_pullup_o(pc_pu), .pd_out_o(pd_out), .pd_oe_o(pd_oe), .pd_pullup_o(pd_pu),
      .timer_clock_select_o(tcs), .lvd_above_i(lvd_above_i), .mtp_read_en_o(rden), .ram_addr_o(ram_addr),
      .ram_rdata_i(ram_rdata), .mtp_addr_o(mtp_addr), .mtp_wdata_o(mtp_wdata), .mtp_write_o(mtp_wr),
      .mtp_erase_o(mtp_er), .mtp_done_i(mtp_done));
   scr_far_model u_far (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow), .ram_addr_i(ram_addr), .ram_rdata_o(ram_rdata),
      .mtp_write_i(mtp_wr), .mtp_erase_i(mtp_er), .mtp_done_o(mtp_done), .oe_i({pa_oe, pb_oe, pc_oe, pd_oe}),
      .pullup_i({pa_pu, pb_pu, pc_pu, pd_pu}), .ext_i({ext, ext, ext, ext[0]}), .pad_o(pad));

   always #50 clock_i = ~clock_i;

   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [3:0] ram_val(logic [8:0] a);
      return a[3:0] ^ {3'b000, a[4]} ^ 4'h6;
   endfunction : ram_val
   task automatic wr(logic [8:0] a, logic [3:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rc(string what, logic [8:0] a, logic [3:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      chk(what, rdata, exp);
   endtask : rc
   task automatic wait_idle();
      int quiet = 0;
      for (int n = 0; n < 2000 && quiet < 8; n++) begin
         @(posedge clock_i);
         quiet = (mtp_wr || mtp_er) ? 0 : quiet + 1;
      end
      chk("idle", 16'(quiet), 16'h0008);
   endtask : wait_idle

   // Judge each finished byte write
   always @(posedge clock_i) begin
      if (mtp_wr && mtp_done) begin
         chk("mtp_addr", mtp_addr, {exp_page, 4'(nbytes)});
         chk("mtp_wdata", mtp_wdata, {ram_val(ADDR_PG_BUF + 9'(2 * nbytes + 1)),
            ram_val(ADDR_PG_BUF + 9'(2 * nbytes))});
         nbytes++;
      end
   end

   task automatic t_reset_values();
      rc("page_low", ADDR_PAGE_LOW, 4'h0);
      rc("page_hi", ADDR_PAGE_HI, 4'h0);
      rc("ctl", ADDR_MTP_CTL, 4'h2);
      rc("key", ADDR_KEY, 4'h0);
      rc("port_a", ADDR_PORT_A, 4'hf);
      rc("port_d", ADDR_PORT_D, 4'h1);
      rc("tcs", ADDR_TMR_CS, 4'h3);
      rc("supply", ADDR_SUPPLY, 4'h3);
      rc("unmapped", 9'h1ea, 4'h0);
      chk("pullups", {pa_pu, pb_pu, pc_pu, pd_pu}, 16'h1fff);
      chk("read_en", rden, 16'h0001);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_ports();
      @(posedge clock_i);
      ext <= 4'h7;
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_PORT_A + 9'(i), 4'(9 + i));
         rc("port_pad", ADDR_PORT_A + 9'(i), 4'(9 + i) & 4'h7);
      end
      chk("pull_up", {pa_pu, pb_pu, pc_pu}, 16'h09ab);
      chk("drive", {pa_oe, pb_oe, pc_oe}, 16'h0654);
      chk("out_low", {pa_out, pb_out, pc_out, pd_out}, 16'h0000);
      wr(ADDR_PORT_D, 4'h0);
      rc("port_d", ADDR_PORT_D, 4'h0);
      chk("pd_oe", pd_oe, 16'h0001);
      wr(ADDR_PORT_D, 4'hf);
      rc("port_d", ADDR_PORT_D, 4'h1);
      ext <= 4'hf;
      $display("test ports done");
   endtask : t_ports

   task automatic t_tcs();
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_TMR_CS, 4'(12 + c));
         rc("tcs", ADDR_TMR_CS, 4'(c));
         chk("tcs_out", tcs, 16'(c));
      end
      $display("test timer_source done");
   endtask : t_tcs

   task automatic t_program();
      wr(ADDR_PAGE_LOW, 4'h5);
      wr(ADDR_PAGE_HI, 4'hf);
      rc("page_hi", ADDR_PAGE_HI, 4'h3);
      exp_page = 6'h35;
      wr(ADDR_KEY, 4'ha);
      wr(ADDR_MTP_CTL, 4'h6);
      rc("busy", ADDR_MTP_CTL, 4'h3);
      wait_idle();
      chk("bytes", 16'(nbytes), 16'h0010);
      rc("finish", ADDR_MTP_CTL, 4'h3);
      wr(ADDR_MTP_CTL, 4'h2);
      rc("cleared", ADDR_MTP_CTL, 4'h2);
      wr(ADDR_MTP_CTL, 4'h6);
      rc("no_rearm", ADDR_MTP_CTL, 4'h2);
      $display("test program done");
   endtask : t_program

   task automatic t_erase();
      slow <= 1'b1;
      wr(ADDR_KEY, 4'ha);
      wr(ADDR_KEY, 4'h5);
      wr(ADDR_MTP_CTL, 4'ha);
      rc("bad_key", ADDR_MTP_CTL, 4'h2);
      wr(ADDR_KEY, 4'ha);
      wr(ADDR_MTP_CTL, 4'ha);
      rc("erasing", ADDR_MTP_CTL, 4'h3);
      wait_idle();
      rc("erased", ADDR_MTP_CTL, 4'h3);
      wr(ADDR_MTP_CTL, 4'h0);
      rc("rd_off", ADDR_MTP_CTL, 4'h0);
      chk("read_en", rden, 16'h0000);
      slow <= 1'b0;
      $display("test erase done");
   endtask : t_erase

   task automatic t_supply();
      @(posedge clock_i);
      lvd_above_i <= 1'b0;
      rc("low_supply", ADDR_SUPPLY, 4'h2);
      wr(ADDR_SUPPLY, 4'hf);
      rc("set_ignored", ADDR_SUPPLY, 4'h2);
      wr(ADDR_SUPPLY, 4'h1);
      rc("por_clear", ADDR_SUPPLY, 4'h0);
      @(posedge clock_i);
      pwr_rst_n_i <= 1'b0;
      @(posedge clock_i);
      pwr_rst_n_i <= 1'b1;
      rc("power_up", ADDR_SUPPLY, 4'h2);
      wr(ADDR_SUPPLY, 4'h0);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock_i);
         rst_n_i     <= 1'b0;
         lvr_cause_i <= 1'(k == 0);
         repeat (2) @(posedge clock_i);
         rst_n_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         lvr_cause_i <= 1'b0;
         rc("por_after_rst", ADDR_SUPPLY, 4'(2 * k));
      end
      $display("test supply done");
   endtask : t_supply

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i     <= 1'b1;
      pwr_rst_n_i <= 1'b1;
      t_reset_values();
      t_ports();
      t_tcs();
      t_program();
      t_erase();
      t_supply();
      end_of_test();
   end
   // Run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clock_i);
      fail_count++;
      end_of_test();
   end
endmodule : scr_reg_bank_tb_top
